// ---- inc/mfit_defs.vh ----
// constants for the multifunction i/o, interrupt and timer block
`ifndef MFIT_DEFS_VH
`define MFIT_DEFS_VH

// ****************************************
// command addresses
// ****************************************
`define MFIT_A_RXBUF 4'h0
`define MFIT_A_XIN 4'h1
`define MFIT_A_VEC 4'h2
`define MFIT_A_STAT 4'h3
`define MFIT_A_DISC 4'h4
`define MFIT_A_RATE 4'h5
`define MFIT_A_TXBUF 4'h6
`define MFIT_A_OUT 4'h7
`define MFIT_A_MASK 4'h8
`define MFIT_A_TMR1 4'h9
`define MFIT_A_TMR5 4'hD

// ****************************************
// discrete command bits
// ****************************************
`define MFIT_DISC_RST 0
`define MFIT_DISC_BRK 1
`define MFIT_DISC_X17 2
`define MFIT_DISC_ACKEN 3

// ****************************************
// sync-time status bits on the data bus
// ****************************************
`define MFIT_SYNC_ACK 0
`define MFIT_SYNC_WO 1

// ****************************************
// status byte bit positions
// ****************************************
`define MFIT_ST_FRAME 0
`define MFIT_ST_OVR 1
`define MFIT_ST_RXD 2
`define MFIT_ST_RXL 3
`define MFIT_ST_TXE 4
`define MFIT_ST_IRQ 5
`define MFIT_ST_BIT 6
`define MFIT_ST_START 7

// ****************************************
// interrupt slots, highest priority first
// ****************************************
`define MFIT_IRQ_T1 0
`define MFIT_IRQ_T2 1
`define MFIT_IRQ_EXT_SENSOR_IN 2
`define MFIT_IRQ_T3 3
`define MFIT_IRQ_RXL 4
`define MFIT_IRQ_TXE 5
`define MFIT_IRQ_T4 6
`define MFIT_IRQ_T5 7

// restart byte: 11 slot 111
`define MFIT_VEC_HI 2'h3
`define MFIT_VEC_LO 3'h7

// ****************************************
// reset values
// ****************************************
`define MFIT_RST_OUT_N 8'hFF
`define MFIT_RST_MASK 8'h00
`define MFIT_RST_RATE 3'h5

// ****************************************
// timing
// ****************************************
`define MFIT_CLK_MHZ 100
`define MFIT_CLK_HZ 100000000
`define MFIT_TICK_US 64
`define MFIT_TICK_CYC (`MFIT_TICK_US * `MFIT_CLK_MHZ)
`define MFIT_BAUD0 200
`define MFIT_BAUD1 300
`define MFIT_BAUD2 600
`define MFIT_BAUD3 1200
`define MFIT_BAUD4 2400
`define MFIT_BAUD5 9600
`define MFIT_BIT_CYC0 (`MFIT_CLK_HZ / `MFIT_BAUD0)
`define MFIT_BIT_CYC1 (`MFIT_CLK_HZ / `MFIT_BAUD1)
`define MFIT_BIT_CYC2 (`MFIT_CLK_HZ / `MFIT_BAUD2)
`define MFIT_BIT_CYC3 (`MFIT_CLK_HZ / `MFIT_BAUD3)
`define MFIT_BIT_CYC4 (`MFIT_CLK_HZ / `MFIT_BAUD4)
`define MFIT_BIT_CYC5 (`MFIT_CLK_HZ / `MFIT_BAUD5)

`endif

// ---- hw/mfit_uart_rx.v ----
// asynchronous serial receiver, one start, eight data, one stop bit
`timescale 1ns/1ns
module mfit_uart_rx #(
    parameter CW = 20
) (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // serial line, already synchronised
    input wire rxd,
    input wire [CW-1:0] bit_cyc,
    // received character
    output reg [7:0] rx_data,
    output reg rx_done,
    output reg rx_ferr,
    // detector states
    output wire start_det,
    output wire bit_det
);

    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_START = 2'h1;
    localparam [1:0] ST_DATA = 2'h2;
    localparam [1:0] ST_STOP = 2'h3;

    reg [1:0] st_q;
    reg [CW-1:0] cnt_q;
    reg [2:0] bits_q;
    reg [7:0] sh_q;

    assign start_det = (st_q == ST_START);
    assign bit_det = (st_q == ST_DATA);

    // ****************************************
    // receive sequencer
    // ****************************************
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= ST_IDLE;
            cnt_q <= {CW{1'b0}};
            bits_q <= 3'h0;
            sh_q <= 8'h00;
            rx_data <= 8'h00;
            rx_done <= 1'b0;
            rx_ferr <= 1'b0;
        end else begin
            rx_done <= 1'b0;
            case (st_q)
                ST_IDLE: begin
                    if (!rxd) begin
                        cnt_q <= bit_cyc >> 1;
                        st_q <= ST_START;
                    end
                end
                ST_START: begin
                    if (cnt_q != {CW{1'b0}}) begin
                        cnt_q <= cnt_q - 1'b1;
                    end else if (!rxd) begin
                        cnt_q <= bit_cyc - 1'b1;
                        bits_q <= 3'h0;
                        st_q <= ST_DATA;
                    end else begin
                        st_q <= ST_IDLE;
                    end
                end
                ST_DATA: begin
                    if (cnt_q != {CW{1'b0}}) begin
                        cnt_q <= cnt_q - 1'b1;
                    end else begin
                        sh_q <= {rxd, sh_q[7:1]};
                        cnt_q <= bit_cyc - 1'b1;
                        if (bits_q == 3'h7) begin
                            st_q <= ST_STOP;
                        end else begin
                            bits_q <= bits_q + 1'b1;
                        end
                    end
                end
                // stop bit checked, character handed on
                ST_STOP: begin
                    if (cnt_q != {CW{1'b0}}) begin
                        cnt_q <= cnt_q - 1'b1;
                    end else begin
                        rx_data <= sh_q;
                        rx_ferr <= ~rxd;
                        rx_done <= 1'b1;
                        st_q <= ST_IDLE;
                    end
                end
                default: begin
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end

endmodule

// ---- hw/mfit_top.v ----
// multifunction i/o block: timers, interrupt unit, ports and serial link
//
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/1ns
`include "mfit_defs.vh"
module mfit_top #(
    parameter TICK_CYC = `MFIT_TICK_CYC,
    parameter BIT_CYC0 = `MFIT_BIT_CYC0,
    parameter BIT_CYC1 = `MFIT_BIT_CYC1,
    parameter BIT_CYC2 = `MFIT_BIT_CYC2,
    parameter BIT_CYC3 = `MFIT_BIT_CYC3,
    parameter BIT_CYC4 = `MFIT_BIT_CYC4,
    parameter BIT_CYC5 = `MFIT_BIT_CYC5
) (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // host command port
    input wire ce,
    input wire [3:0] addr,
    input wire [7:0] wr_data,
    input wire wr,
    input wire rd,
    input wire sync,
    output reg [7:0] rd_data_q,
    output reg irq_q,
    output reg wo_status_q,
    // parallel ports
    input wire [7:0] ext_in_port,
    input wire ext_sensor_in,
    output reg [7:0] ext_out_port_n_q,
    // serial line
    input wire rxd,
    output reg txd_q
);

    localparam CW = 20;
    localparam [31:0] TICK_M1 = TICK_CYC - 1;
    localparam [12:0] TICK_LAST = TICK_M1[12:0];

    // ****************************************
    // reset release and pin synchronisers
    // ****************************************
    reg rst_m_q;
    reg rst_s_n;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_m_q <= 1'b0;
            rst_s_n <= 1'b0;
        end else begin
            rst_m_q <= 1'b1;
            rst_s_n <= rst_m_q;
        end
    end

    reg [9:0] pin_m_q;
    reg [9:0] pin_s_q;
    always @(posedge clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            pin_m_q <= 10'h3FF;
            pin_s_q <= 10'h3FF;
        end else begin
            pin_m_q <= {rxd, ext_sensor_in, ext_in_port};
            pin_s_q <= pin_m_q;
        end
    end
    wire [7:0] xin_s = pin_s_q[7:0];
    wire ext_sensor_in_s = pin_s_q[8];
    wire rxd_s = pin_s_q[9];

    // ****************************************
    // command decode
    // ****************************************
    // address commands decode only with enable; sync and the acknowledge read work without it
    wire wr_ok = wr & ce;
    wire rd_ok = rd & ce;
    wire wr_disc = wr_ok && (addr == `MFIT_A_DISC);
    wire wr_rate = wr_ok && (addr == `MFIT_A_RATE);
    wire wr_txb = wr_ok && (addr == `MFIT_A_TXBUF);
    wire wr_out = wr_ok && (addr == `MFIT_A_OUT);
    wire wr_mask = wr_ok && (addr == `MFIT_A_MASK);
    wire rd_rxb = rd_ok && (addr == `MFIT_A_RXBUF);
    wire rd_stat = rd_ok && (addr == `MFIT_A_STAT);
    wire soft_rst = wr_disc && wr_data[`MFIT_DISC_RST];

    function [2:0] first_set;
        input [7:0] v;
        integer i;
        begin
            first_set = 3'h7;
            for (i = 7; i >= 0; i = i - 1) begin
                if (v[i]) begin
                    first_set = i[2:0];
                end
            end
        end
    endfunction

    // ****************************************
    // control registers
    // ****************************************
    reg brk_q;
    reg x17_en_q;
    reg ack_en_q;
    reg [7:0] mask_q;
    reg [2:0] rate_q;
    reg ack_q;
    reg irq_ack_status_rd;
    always @(posedge clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            brk_q <= 1'b0;
            x17_en_q <= 1'b0;
            ack_en_q <= 1'b0;
            mask_q <= `MFIT_RST_MASK;
            rate_q <= `MFIT_RST_RATE;
            ext_out_port_n_q <= `MFIT_RST_OUT_N;
            ack_q <= 1'b0;
            wo_status_q <= 1'b0;
        end else begin
            if (wr_disc) begin
                brk_q <= wr_data[`MFIT_DISC_BRK];
                x17_en_q <= wr_data[`MFIT_DISC_X17];
                ack_en_q <= wr_data[`MFIT_DISC_ACKEN];
            end
            // lowest set bit of the low six selects baud
            if (wr_rate && (wr_data[5:0] != 6'h00)) begin
                rate_q <= first_set({2'h0, wr_data[5:0]});
            end
            // port changes only on a load-output command
            if (wr_out) begin
                ext_out_port_n_q <= ~wr_data;
            end
            if (wr_mask) begin
                mask_q <= wr_data;
            end
            if (sync) begin
                ack_q <= wr_data[`MFIT_SYNC_ACK];
                wo_status_q <= wr_data[`MFIT_SYNC_WO];
            end else if (rd) begin
                ack_q <= 1'b0;
            end
        end
    end

    reg [CW-1:0] bit_cyc;
    always @* begin
        case (rate_q)
            3'h0: bit_cyc = BIT_CYC0[CW-1:0];
            3'h1: bit_cyc = BIT_CYC1[CW-1:0];
            3'h2: bit_cyc = BIT_CYC2[CW-1:0];
            3'h3: bit_cyc = BIT_CYC3[CW-1:0];
            3'h4: bit_cyc = BIT_CYC4[CW-1:0];
            default: bit_cyc = BIT_CYC5[CW-1:0];
        endcase
    end

    // ****************************************
    // timer prescaler and interval timers
    // ****************************************
    reg [12:0] pre_q;
    reg tick_q;
    // shared divider for the 64 us tick
    always @(posedge clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            pre_q <= 13'h0000;
            tick_q <= 1'b0;
        end else begin
            tick_q <= (pre_q == TICK_LAST);
            if (pre_q == TICK_LAST) begin
                pre_q <= 13'h0000;
            end else begin
                pre_q <= pre_q + 1'b1;
            end
        end
    end

    wire [4:0] tfire;
    genvar g;
    generate
        for (g = 0; g < 5; g = g + 1) begin : tmr
            localparam [31:0] TA_W = `MFIT_A_TMR1 + g;
            localparam [3:0] TA = TA_W[3:0];
            reg [7:0] cnt_q;
            reg act_q;
            reg fire_q;
            wire load = wr_ok && (addr == TA);
            assign tfire[g] = fire_q;
            always @(posedge clk or negedge rst_s_n) begin
                if (!rst_s_n) begin
                    cnt_q <= 8'h00;
                    act_q <= 1'b0;
                    fire_q <= 1'b0;
                end else begin
                    fire_q <= 1'b0;
                    // a nonzero load restarts the count, a zero load fires at once
                    if (load) begin
                        cnt_q <= wr_data;
                        act_q <= (wr_data != 8'h00);
                        fire_q <= (wr_data == 8'h00);
                    // one step per tick while running
                    end else if (tick_q && act_q) begin
                        cnt_q <= cnt_q - 1'b1;
                        if (cnt_q == 8'h01) begin
                            act_q <= 1'b0;
                            fire_q <= 1'b1;
                        end
                    end
                end
            end
        end
    endgenerate

    // ****************************************
    // serial receiver
    // ****************************************
    wire [7:0] rx_data;
    wire rx_done;
    wire rx_ferr;
    wire start_det;
    wire bit_det;
    mfit_uart_rx #(
        .CW(CW)
    ) u_rx (
        .clk(clk),
        .rst_n(rst_s_n),
        .rxd(rxd_s),
        .bit_cyc(bit_cyc),
        .rx_data(rx_data),
        .rx_done(rx_done),
        .rx_ferr(rx_ferr),
        .start_det(start_det),
        .bit_det(bit_det)
    );

    reg [7:0] rxbuf_q;
    reg rxl_q;
    reg ovr_q;
    reg ferr_q;
    // receive flags, a setting event beats a clear
    always @(posedge clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            rxbuf_q <= 8'h00;
            rxl_q <= 1'b0;
            ovr_q <= 1'b0;
            ferr_q <= 1'b0;
        end else begin
            if (rx_done) begin
                rxbuf_q <= rx_data;
                ferr_q <= rx_ferr;
                rxl_q <= 1'b1;
            end else if (rd_rxb || soft_rst) begin
                rxl_q <= 1'b0;
            end
            if (rx_done && rxl_q && !rd_rxb) begin
                ovr_q <= 1'b1;
            end else if (rd_stat || soft_rst) begin
                ovr_q <= 1'b0;
            end
        end
    end

    // ****************************************
    // serial transmitter
    // ****************************************
    reg [7:0] txbuf_q;
    reg txe_q;
    reg [9:0] tsh_q;
    reg [3:0] tbits_q;
    reg [CW-1:0] tcnt_q;
    reg txe_ev;
    wire tx_idle = (tbits_q == 4'h0);
    always @(posedge clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            txbuf_q <= 8'h00;
            txe_q <= 1'b1;
            tsh_q <= 10'h3FF;
            tbits_q <= 4'h0;
            tcnt_q <= {CW{1'b0}};
            txe_ev <= 1'b0;
            txd_q <= 1'b1;
        end else begin
            txe_ev <= 1'b0;
            txd_q <= brk_q ? 1'b0 : tsh_q[0];
            if (soft_rst) begin
                txe_q <= 1'b1;
                tsh_q <= 10'h3FF;
                tbits_q <= 4'h0;
            end else if (tx_idle && !txe_q) begin
                // frame: start low, data lsb first, stop high
                tsh_q <= {1'b1, txbuf_q, 1'b0};
                tbits_q <= 4'hA;
                tcnt_q <= bit_cyc - 1'b1;
                txe_q <= wr_txb ? 1'b0 : 1'b1;
                txe_ev <= 1'b1;
            end else if (!tx_idle) begin
                if (tcnt_q != {CW{1'b0}}) begin
                    tcnt_q <= tcnt_q - 1'b1;
                end else begin
                    tsh_q <= {1'b1, tsh_q[9:1]};
                    tbits_q <= tbits_q - 1'b1;
                    tcnt_q <= bit_cyc - 1'b1;
                end
            end
            if (wr_txb) begin
                txbuf_q <= wr_data;
                if (!soft_rst) begin
                    txe_q <= 1'b0;
                end
            end
        end
    end

    // ****************************************
    // interrupt register, mask and priority
    // ****************************************
    reg ext_sensor_in_p_q;
    reg x7_p_q;
    reg [7:0] pend_q;
    always @(posedge clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            // match synchroniser reset level, no false edge
            ext_sensor_in_p_q <= 1'b1;
            x7_p_q <= 1'b1;
        end else begin
            ext_sensor_in_p_q <= ext_sensor_in_s;
            x7_p_q <= xin_s[7];
        end
    end

    // slot order fixed by source wiring
    wire [7:0] src;
    assign src[`MFIT_IRQ_T1] = tfire[0];
    assign src[`MFIT_IRQ_T2] = tfire[1];
    assign src[`MFIT_IRQ_EXT_SENSOR_IN] = ext_sensor_in_s & ~ext_sensor_in_p_q;
    assign src[`MFIT_IRQ_T3] = tfire[2];
    assign src[`MFIT_IRQ_RXL] = rx_done;
    assign src[`MFIT_IRQ_TXE] = txe_ev;
    assign src[`MFIT_IRQ_T4] = tfire[3];
    // input bit 7 shares the last slot when enabled
    assign src[`MFIT_IRQ_T5] = tfire[4] | (x17_en_q & xin_s[7] & ~x7_p_q);

    // mask gates pending bits into priority
    wire [7:0] live = pend_q & mask_q;
    // lowest index wins while it stays pending
    wire [2:0] win = first_set(live);
    // restart byte from the winning slot
    wire [7:0] vec = {`MFIT_VEC_HI, win, `MFIT_VEC_LO};

    // acknowledge read, only with acknowledge enabled
    always @* begin
        irq_ack_status_rd = rd & ack_q & ack_en_q;
    end
    wire vec_rd = irq_ack_status_rd | (rd_ok && (addr == `MFIT_A_VEC));

    reg [7:0] pend_d;
    reg [7:0] clr;
    always @* begin
        clr = 8'h00;
        // reported slot cleared by vector read
        if (vec_rd && (live != 8'h00)) begin
            clr[win] = 1'b1;
        end
        if (soft_rst) begin
            clr = 8'hFF;
        end
        pend_d = (pend_q & ~clr) | src;
    end

    always @(posedge clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            pend_q <= 8'h00;
            irq_q <= 1'b0;
        end else begin
            pend_q <= pend_d;
            irq_q <= |(pend_d & (wr_mask ? wr_data : mask_q));
        end
    end

    // ****************************************
    // read data
    // ****************************************
    always @(posedge clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            rd_data_q <= 8'h00;
        end else if (irq_ack_status_rd) begin
            rd_data_q <= vec;
        end else if (rd_ok) begin
            case (addr)
                `MFIT_A_RXBUF: rd_data_q <= rxbuf_q;
                `MFIT_A_XIN: rd_data_q <= xin_s;
                `MFIT_A_VEC: rd_data_q <= vec;
                `MFIT_A_STAT: rd_data_q <= {start_det, bit_det, irq_q,
                    txe_q, rxl_q, rxd_s, ovr_q, ferr_q};
                default: rd_data_q <= 8'h00;
            endcase
        end else begin
            rd_data_q <= 8'h00;
        end
    end

endmodule

// ---- testbench/mfit_props.sv ----
// port assertions for the multifunction i/o block
`timescale 1ns/1ns
module mfit_props (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // host port
    input wire ce,
    input wire [3:0] addr,
    input wire [7:0] wr_data,
    input wire wr,
    input wire rd,
    input wire sync,
    input wire [7:0] rd_data_q,
    input wire irq_q,
    input wire wo_status_q,
    // pins
    input wire [7:0] ext_in_port,
    input wire ext_sensor_in,
    input wire [7:0] ext_out_port_n_q,
    input wire rxd,
    input wire txd_q
);
    // ****
    // properties
    // ****
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence out_wr;
        wr && addr == 4'h7 && !sync;
    endsequence
    sequence in_steady;
        $stable(ext_in_port) [*4];
    endsequence
    idle_zero_a: assert property (!rd |=> rd_data_q == 8'h00)
        else $error("read data not zero");
    ce_block_a: assert property (
        out_wr ##0 !ce |=> $stable(ext_out_port_n_q))
        else $error("write ran with ce low");
    out_load_a: assert property (
        out_wr ##0 ce |=> ext_out_port_n_q == ~$past(wr_data))
        else $error("output port not loaded");
    out_hold_a: assert property (
        !(wr && ce && addr == 4'h7) |=> $stable(ext_out_port_n_q))
        else $error("output port moved");
    in_read_a: assert property (
        in_steady ##0 (rd && ce && addr == 4'h1)
        |=> rd_data_q == $past(ext_in_port))
        else $error("input read wrong");
    stat_irq_a: assert property (
        rd && ce && addr == 4'h3 && !sync |=> rd_data_q[5] == $past(irq_q))
        else $error("pending bit differs from irq");
    mask_off_a: assert property (
        wr && ce && addr == 4'h8 && wr_data == 8'h00 && !sync
        |=> ##1 !irq_q [*2])
        else $error("irq with empty mask");
    vec_form_a: assert property (
        rd && ce && addr == 4'h2
        |=> rd_data_q[7:6] == 2'h3 && rd_data_q[2:0] == 3'h7)
        else $error("vector not a restart byte");
    wo_track_a: assert property (
        sync |=> wo_status_q == $past(wr_data[1]))
        else $error("write status not sampled");
endmodule

bind mfit_top mfit_props u_props (.clk(clk), .rst_n(rst_n), .ce(ce),
    .addr(addr), .wr_data(wr_data), .wr(wr), .rd(rd), .sync(sync),
    .rd_data_q(rd_data_q), .irq_q(irq_q), .wo_status_q(wo_status_q),
    .ext_in_port(ext_in_port), .ext_sensor_in(ext_sensor_in),
    .ext_out_port_n_q(ext_out_port_n_q), .rxd(rxd), .txd_q(txd_q));

// ---- testbench/mfit_ser_peer.sv ----
// serial far end: echoes the transmit line back
`timescale 1ns/1ns
module mfit_ser_peer (
    // clock
    input wire clk,
    // serial line
    input wire txd,
    output reg rxd
);
    // loop back one cycle late
    always @(posedge clk) begin
        rxd <= txd;
    end
endmodule

// ---- testbench/mfit_top_tb.sv ----
// self-checking bench for the multifunction i/o block
`timescale 1ns/1ns
module mfit_top_tb;
    reg clk = 1'b0;
    reg rst_n = 1'b0;
    reg ce = 1'b0;
    reg [3:0] addr = 4'h0;
    reg [7:0] wr_data = 8'h00;
    reg wr = 1'b0;
    reg rd = 1'b0;
    reg sync = 1'b0;
    reg [7:0] ext_in_port = 8'h00;
    reg ext_sensor_in = 1'b0;
    wire [7:0] rd_data_q;
    wire irq_q;
    wire wo_status_q;
    wire [7:0] ext_out_port_n_q;
    wire rxd;
    wire txd_q;
    integer fail_count = 0;
    integer num_checks = 0;
    integer pend = 0;
    integer i;
    reg [31:0] seed = 32'h53E5DD0C;
    reg [7:0] v;

    always #5 clk = ~clk;

    mfit_top #(.TICK_CYC(8), .BIT_CYC2(16),
        .BIT_CYC3(16), .BIT_CYC4(16), .BIT_CYC5(16)) u_mfit_top (
        .clk(clk), .rst_n(rst_n), .ce(ce), .addr(addr), .wr_data(wr_data),
        .wr(wr), .rd(rd), .sync(sync), .rd_data_q(rd_data_q), .irq_q(irq_q),
        .wo_status_q(wo_status_q), .ext_in_port(ext_in_port),
        .ext_sensor_in(ext_sensor_in), .ext_out_port_n_q(ext_out_port_n_q),
        .rxd(rxd), .txd_q(txd_q));
    mfit_ser_peer u_mfit_ser_peer (.clk(clk), .txd(txd_q), .rxd(rxd));

    // ****
    // model and tasks
    // ****
    function [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // lowest live slot wins, ff when none
    function [7:0] exp_vec(input integer p);
        integer s;
        begin
            exp_vec = 8'hFF;
            for (s = 7; s >= 0; s = s - 1)
                if (p[s]) exp_vec = {2'h3, s[2:0], 3'h7};
        end
    endfunction
    task chk(input [7:0] got, input [7:0] exp);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                fail_count = fail_count + 1;
                $display("Error at %0t: got %h, expected %h", $time, got, exp);
            end
        end
    endtask
    // host drives ce and four address bits
    task wr_t(input [3:0] a, input [7:0] d, input c);
        begin
            @(posedge clk);
            ce <= c;
            addr <= a;
            wr_data <= d;
            wr <= 1'b1;
            @(posedge clk);
            wr <= 1'b0;
        end
    endtask
    task rd_t(input [3:0] a, input [7:0] e);
        begin
            @(posedge clk);
            addr <= a;
            rd <= 1'b1;
            @(posedge clk);
            rd <= 1'b0;
            #1 chk(rd_data_q, e);
        end
    endtask
    task vec_rd;
        begin
            v = exp_vec(pend);
            rd_t(4'h2, v);
            if (pend != 0) pend[v[5:3]] = 0;
        end
    endtask
    task results;
        begin
            $display("checks %0d errors %0d", num_checks, fail_count);
            if (fail_count == 0 && num_checks > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        fail_count = fail_count + 1;
        results;
    end

    // ****
    // scenarios
    // ****
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (5) @(posedge clk);
        #1 chk(ext_out_port_n_q, 8'hFF);
        chk({6'h0, irq_q, txd_q}, 8'h01);
        wr_t(4'h4, 8'h02, 1'b1);
        repeat (3) @(posedge clk);
        #1 chk({7'h0, txd_q}, 8'h00);
        wr_t(4'h4, 8'h00, 1'b1);
        repeat (400) @(posedge clk);
        for (i = 0; i < 6; i = i + 1)
            wr_t(4'h5, 8'h01 << i, 1'b1);
        wr_t(4'h4, 8'h01, 1'b1);
        wr_t(4'h8, 8'hFF, 1'b1);
        for (i = 0; i < 4; i = i + 1) begin
            seed = lfsr(seed);
            wr_t(4'h7, seed[7:0], 1'b1);
            wr_t(4'h7, seed[23:16], 1'b0);
            ext_in_port <= seed[15:8];
            ce <= 1'b1;
            repeat (4) @(posedge clk);
            #1 chk(ext_out_port_n_q, ~seed[7:0]);
            rd_t(4'h1, seed[15:8]);
        end
        wr_t(4'h6, 8'hA5, 1'b1);
        pend[5] = 1;
        repeat (400) @(posedge clk);
        pend[4] = 1;
        ext_sensor_in <= 1'b1;
        pend[2] = 1;
        for (i = 0; i < 5; i = i + 1) begin
            wr_t(4'h9 + i[3:0], 8'h00, 1'b1);
            pend[i < 2 ? i : (i == 2 ? 3 : i + 3)] = 1;
        end
        repeat (5) @(posedge clk);
        #1 chk({7'h0, irq_q}, 8'h01);
        rd_t(4'h3, 8'h3C);
        rd_t(4'h0, 8'hA5);
        for (i = 0; i < 9; i = i + 1)
            vec_rd;
        #1 chk({7'h0, irq_q}, 8'h00);
        wr_t(4'h9, 8'h03, 1'b1);
        repeat (12) @(posedge clk);
        wr_t(4'h9, 8'h03, 1'b1);
        repeat (13) @(posedge clk);
        #1 chk({7'h0, irq_q}, 8'h00);
        repeat (20) @(posedge clk);
        #1 chk({7'h0, irq_q}, 8'h01);
        wr_t(4'h8, 8'h00, 1'b1);
        repeat (3) @(posedge clk);
        #1 chk({7'h0, irq_q}, 8'h00);
        wr_t(4'h8, 8'hFF, 1'b1);
        pend[0] = 1;
        vec_rd;
        repeat (60) @(posedge clk);
        #1 chk({7'h0, irq_q}, 8'h00);
        wr_t(4'h4, 8'h08, 1'b1);
        wr_t(4'hA, 8'h00, 1'b1);
        pend[1] = 1;
        repeat (4) @(posedge clk);
        sync <= 1'b1;
        wr_data <= 8'h03;
        ce <= 1'b0;
        @(posedge clk);
        sync <= 1'b0;
        vec_rd;
        repeat (3) @(posedge clk);
        #1 chk({6'h0, wo_status_q, irq_q}, 8'h02);
        results;
    end
endmodule
